// file: rtl/status_led_fault_indicator.sv
// Two-colour status LED driver with fault flash codes and output trips.
// Assumes all inputs are synchronous to i_clock and strobes are one cycle long.
//
// What this block does
// RQ1 - Flash green version count after power-up
// RQ2 - Panel-bus mode, no fault: steady green
// RQ3 - Panel-bus data strobe blanks green briefly
// RQ4 - Continuous panel-bus data gives slow flash
// RQ5 - DMX mode with data: slow green flash
// RQ6 - DMX mode without data: steady green
// RQ7 - Faults override green, flash red code
// RQ8 - Multiple faults: groups in turn, dark gaps
// RQ9 - Codes one/two: pan/tilt limits reached
// RQ10 - Codes three-five: motor over-current, timed disable
// RQ11 - Over-current held until condition clears
// RQ12 - Code six: bus supply trips until power-cycle
// RQ13 - Code seven: heater trips until power-cycle
// RQ14 - Code eight: limit input unused by product
// RQ15 - Code nine: datum routine failed
// RQ16 - Code ten: product type invalid
// RQ17 - Code eleven: supply outside window
// RQ18 - Sequence repeats; timings are cycle parameters
// RQ19 - Finish current group before resuming green
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

module status_led_fault_indicator #(
	parameter int unsigned FLASH_ON_CYC  = status_led_pkg::FLASH_ON_CYC,
	parameter int unsigned FLASH_OFF_CYC = status_led_pkg::FLASH_OFF_CYC,
	parameter int unsigned GAP_CYC       = status_led_pkg::GAP_CYC,
	parameter int unsigned SLOW_HALF_CYC = status_led_pkg::SLOW_HALF_CYC,
	parameter int unsigned DMX_LOSS_CYC  = status_led_pkg::DMX_LOSS_CYC,
	parameter int unsigned OC_HOLD_CYC   = status_led_pkg::OC_HOLD_CYC
) (
	// Clock and reset
	input  wire logic                                  i_clock,
	input  wire logic                                  i_rst_n,
	// Operating mode and data activity
	input  wire logic                                  i_dmx_mode,
	input  wire logic                                  i_bus_data_valid,
	input  wire logic                                  i_dmx_data_valid,
	// Fault sensing
	input  wire logic [status_led_pkg::LIMIT_W-1:0]    i_limit_sw,
	input  wire logic                                  i_pan_var_limit,
	input  wire logic                                  i_tilt_var_limit,
	input  wire logic [status_led_pkg::MOTORS-1:0]     i_motor_oc,
	input  wire logic                                  i_bus_supply_oc,
	input  wire logic                                  i_heater_oc,
	input  wire logic                                  i_datum_fail,
	input  wire logic                                  i_product_bad,
	input  wire logic                                  i_supply_bad,
	// Register port
	input  wire logic [status_led_pkg::ADDR_W-1:0]     i_addr,
	input  wire logic [status_led_pkg::DATA_W-1:0]     i_wdata,
	input  wire logic                                  i_wr,
	input  wire logic                                  i_rd,
	output logic      [status_led_pkg::DATA_W-1:0]     o_rdata,
	// LED, power and interrupt outputs
	output logic                                       o_led_green,
	output logic                                       o_led_red,
	output logic      [status_led_pkg::MOTORS-1:0]     o_motor_en,
	output logic                                       o_bus_supply_en,
	output logic                                       o_heater_en,
	output logic                                       o_irq
);

	localparam int TW = status_led_pkg::TIMER_W;
	localparam int NC = status_led_pkg::NUM_CODES;
	localparam int CW = status_led_pkg::CODE_W;
	localparam logic [TW-1:0] ON_LAST   = TW'(FLASH_ON_CYC - 1);
	localparam logic [TW-1:0] OFF_LAST  = TW'(FLASH_OFF_CYC - 1);
	localparam logic [TW-1:0] GAP_LAST  = TW'(GAP_CYC - 1);
	localparam logic [TW-1:0] SLOW_LAST = TW'(SLOW_HALF_CYC - 1);
	localparam logic [TW-1:0] SLOW_HALF = TW'(SLOW_HALF_CYC);
	localparam logic [TW-1:0] ACT_LOAD  = TW'(2 * SLOW_HALF_CYC - 1);
	localparam logic [TW-1:0] DMX_LOAD  = TW'(DMX_LOSS_CYC);
	localparam logic [TW-1:0] OC_LOAD   = TW'(OC_HOLD_CYC);

	// Next active fault code after 'after', wrapping round to 'after' itself last; none gives zero
	function automatic logic [CW-1:0] next_fault(input logic [NC-1:0] vec,
		input logic [CW-1:0] after);
		int c;
		next_fault = status_led_pkg::CODE_NONE;
		for (int k = NC; k >= 1; k--) begin
			c = ((int'(after) + k - 1) % NC) + 1;
			if (vec[c-1]) begin
				next_fault = CW'(c);
			end
		end
	endfunction

	status_led_pkg::led_state_t state;
	logic [TW-1:0]              timer;
	logic [7:0]                 flash_cnt;
	logic [CW-1:0]              code;
	logic [NC-1:0]              fault_q;
	logic [NC-1:0]              fault_d;
	logic [NC-1:0]              irq_status;
	logic [NC-1:0]              irq_mask;
	logic [status_led_pkg::LIMIT_W-1:0] limit_use;
	logic [status_led_pkg::MOTORS-1:0]  oc_flag;
	logic                       bus_trip;
	logic                       heater_trip;
	logic [TW-1:0]              act_cnt;
	logic [TW-1:0]              dmx_cnt;
	logic [TW-1:0]              slow_cnt;
	logic                       slow_phase;
	logic                       normal_green;
	logic                       fault_any;
	logic                       wr_status;

	// Per-motor over-current: drive off for a hold time, flag kept while condition lasts
	generate
		for (genvar m = 0; m < status_led_pkg::MOTORS; m++) begin : g_motor
			logic [TW-1:0] hold;
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					hold          <= '0;
					oc_flag[m]    <= 1'b0;
					o_motor_en[m] <= 1'b0;
				end else begin
					if (i_motor_oc[m]) begin
						hold <= OC_LOAD; // [RQ10]
					end else if (hold != '0) begin
						hold <= hold - 1'b1;
					end
					// Indication clears only once the condition and hold are both gone
					oc_flag[m]    <= i_motor_oc[m] || (oc_flag[m] && hold != '0); // [RQ11]
					o_motor_en[m] <= !i_motor_oc[m] && hold == '0; // [RQ10]
				end
			end
		end
	endgenerate

	// Supply and heater trips stay set until reset, i.e. power cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_trip        <= 1'b0;
			heater_trip     <= 1'b0;
			o_bus_supply_en <= 1'b0;
			o_heater_en     <= 1'b0;
		end else begin
			bus_trip        <= bus_trip || i_bus_supply_oc; // [RQ12]
			heater_trip     <= heater_trip || i_heater_oc; // [RQ13]
			o_bus_supply_en <= !bus_trip && !i_bus_supply_oc; // [RQ12]
			o_heater_en     <= !heater_trip && !i_heater_oc; // [RQ13]
		end
	end

	// Fault vector, one bit per code; registered so the sequencer sees stable flags
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_q <= '0;
			fault_d <= '0;
		end else begin
			fault_d <= fault_q;
			fault_q[status_led_pkg::CODE_PAN_LIMIT-1]  <= i_limit_sw[status_led_pkg::LIM_PAN_CW]
				|| i_limit_sw[status_led_pkg::LIM_PAN_CCW] || i_pan_var_limit; // [RQ9]
			fault_q[status_led_pkg::CODE_TILT_LIMIT-1] <= i_limit_sw[status_led_pkg::LIM_TILT_UP]
				|| i_limit_sw[status_led_pkg::LIM_TILT_DN] || i_tilt_var_limit; // [RQ9]
			fault_q[status_led_pkg::CODE_PAN_OC-1]     <= oc_flag[0]; // [RQ10]
			fault_q[status_led_pkg::CODE_TILT_OC-1]    <= oc_flag[1]; // [RQ10]
			fault_q[status_led_pkg::CODE_FOCUS_OC-1]   <= oc_flag[2]; // [RQ10]
			fault_q[status_led_pkg::CODE_BUS_OC-1]     <= bus_trip; // [RQ12]
			fault_q[status_led_pkg::CODE_HEATER_OC-1]  <= heater_trip; // [RQ13]
			fault_q[status_led_pkg::CODE_LIMIT_ERR-1]  <= |(i_limit_sw & ~limit_use); // [RQ14]
			fault_q[status_led_pkg::CODE_DATUM-1]      <= i_datum_fail; // [RQ15]
			fault_q[status_led_pkg::CODE_PRODUCT-1]    <= i_product_bad; // [RQ16]
			fault_q[status_led_pkg::CODE_SUPPLY-1]     <= i_supply_bad; // [RQ17]
		end
	end

	assign fault_any = |fault_q;

	// Panel-bus activity: blank half a slow period, then a guard half that ignores
	// strobes, so back-to-back data turns into a slow flash instead of steady dark
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_cnt <= '0;
		end else if (act_cnt != '0) begin
			act_cnt <= act_cnt - 1'b1;
		end else if (i_bus_data_valid && !i_dmx_mode) begin
			act_cnt <= ACT_LOAD; // [RQ3] [RQ4]
		end
	end

	// DMX presence timeout and free-running slow flash phase
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dmx_cnt    <= '0;
			slow_cnt   <= '0;
			slow_phase <= 1'b1;
		end else begin
			if (i_dmx_data_valid) begin
				dmx_cnt <= DMX_LOAD;
			end else if (dmx_cnt != '0) begin
				dmx_cnt <= dmx_cnt - 1'b1;
			end
			if (slow_cnt == SLOW_LAST) begin
				slow_cnt   <= '0;
				slow_phase <= !slow_phase;
			end else begin
				slow_cnt <= slow_cnt + 1'b1;
			end
		end
	end

	// Green level for normal indication in the current mode
	always_comb begin
		if (i_dmx_mode) begin
			normal_green = (dmx_cnt != '0) ? slow_phase : 1'b1; // [RQ5] [RQ6]
		end else begin
			normal_green = !(act_cnt >= SLOW_HALF); // [RQ2] [RQ3]
		end
	end

	// Flash sequencer: version count, then normal or fault groups
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state     <= status_led_pkg::ST_VER_ON;
			timer     <= '0;
			flash_cnt <= '0;
			code      <= status_led_pkg::CODE_NONE;
		end else begin
			unique case (state)
				status_led_pkg::ST_VER_ON: begin
					if (status_led_pkg::SW_VERSION == 8'h00) begin
						state <= status_led_pkg::ST_NORMAL;
					end else if (timer == ON_LAST) begin
						timer     <= '0;
						flash_cnt <= flash_cnt + 1'b1;
						state     <= status_led_pkg::ST_VER_OFF; // [RQ1]
					end else begin
						timer <= timer + 1'b1;
					end
				end
				status_led_pkg::ST_VER_OFF: begin
					if (timer == OFF_LAST) begin
						timer <= '0;
						if (flash_cnt == status_led_pkg::SW_VERSION) begin
							flash_cnt <= '0;
							state     <= status_led_pkg::ST_NORMAL; // [RQ1]
						end else begin
							state <= status_led_pkg::ST_VER_ON;
						end
					end else begin
						timer <= timer + 1'b1;
					end
				end
				status_led_pkg::ST_NORMAL: begin
					timer <= '0;
					if (fault_any) begin
						code      <= next_fault(fault_q, status_led_pkg::CODE_NONE); // [RQ7]
						flash_cnt <= '0;
						state     <= status_led_pkg::ST_FAULT_ON; // [RQ7]
					end
				end
				status_led_pkg::ST_FAULT_ON: begin
					if (timer == ON_LAST) begin
						timer     <= '0;
						flash_cnt <= flash_cnt + 1'b1;
						state     <= status_led_pkg::ST_FAULT_OFF;
					end else begin
						timer <= timer + 1'b1;
					end
				end
				status_led_pkg::ST_FAULT_OFF: begin
					if (timer == OFF_LAST) begin
						timer <= '0;
						// The group runs to its full count even if the fault has gone
						if (flash_cnt == 8'(code)) begin
							state <= status_led_pkg::ST_GAP; // [RQ7] [RQ8] [RQ19]
						end else begin
							state <= status_led_pkg::ST_FAULT_ON;
						end
					end else begin
						timer <= timer + 1'b1;
					end
				end
				status_led_pkg::ST_GAP: begin
					if (timer == GAP_LAST) begin
						timer     <= '0;
						flash_cnt <= '0;
						if (fault_any) begin
							code  <= next_fault(fault_q, code); // [RQ8] [RQ18]
							state <= status_led_pkg::ST_FAULT_ON;
						end else begin
							code  <= status_led_pkg::CODE_NONE;
							state <= status_led_pkg::ST_NORMAL; // [RQ19]
						end
					end else begin
						timer <= timer + 1'b1;
					end
				end
			endcase
		end
	end

	// LED drive; red and green never lit together
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_led_green <= 1'b0;
			o_led_red   <= 1'b0;
		end else begin
			o_led_green <= (state == status_led_pkg::ST_VER_ON)
				|| (state == status_led_pkg::ST_NORMAL && normal_green); // [RQ1] [RQ2]
			o_led_red   <= (state == status_led_pkg::ST_FAULT_ON); // [RQ7]
		end
	end

	assign wr_status = i_wr && i_addr == status_led_pkg::OFS_IRQ_STATUS;

	// Interrupt status: a fault onset sets its bit; a written one clears, onset wins
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= '0;
			irq_mask   <= status_led_pkg::IRQ_MASK_RST;
			limit_use  <= status_led_pkg::LIMIT_USE_RST;
			o_irq      <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~(wr_status ? i_wdata[NC-1:0] : '0))
				| (fault_q & ~fault_d);
			if (i_wr && i_addr == status_led_pkg::OFS_IRQ_MASK) begin
				irq_mask <= i_wdata[NC-1:0];
			end
			if (i_wr && i_addr == status_led_pkg::OFS_LIMIT_USE) begin
				limit_use <= i_wdata[status_led_pkg::LIMIT_W-1:0]; // [RQ14]
			end
			o_irq <= |(irq_status & irq_mask);
		end
	end

	// Read data valid the cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= '0;
			case (i_addr)
				status_led_pkg::OFS_IRQ_STATUS: o_rdata[NC-1:0] <= irq_status;
				status_led_pkg::OFS_IRQ_MASK:   o_rdata[NC-1:0] <= irq_mask;
				status_led_pkg::OFS_FAULTS:     o_rdata[NC-1:0] <= fault_q;
				status_led_pkg::OFS_LIMIT_USE: begin
					o_rdata[status_led_pkg::LIMIT_W-1:0] <= limit_use;
				end
				status_led_pkg::OFS_INFO: begin
					o_rdata[7:0] <= status_led_pkg::SW_VERSION;
					o_rdata[status_led_pkg::INFO_CODE_LSB +: CW] <= code;
					o_rdata[status_led_pkg::INFO_MODE_BIT] <= i_dmx_mode;
					o_rdata[status_led_pkg::INFO_GRN_BIT]  <= o_led_green;
					o_rdata[status_led_pkg::INFO_RED_BIT]  <= o_led_red;
				end
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	AST_FAULT_NO_GREEN: assert property ( // [RQ7]
		state inside {status_led_pkg::ST_FAULT_ON, status_led_pkg::ST_FAULT_OFF}
		|=> !o_led_green)
		else $error("green lit during fault flashing");

	AST_RED_ONLY_FAULT: assert property ( // [RQ7]
		o_led_red |-> $past(state) == status_led_pkg::ST_FAULT_ON)
		else $error("red lit outside a fault flash");

	AST_GROUP_END: assert property ( // [RQ8]
		(state == status_led_pkg::ST_FAULT_OFF && timer == OFF_LAST
			&& flash_cnt == 8'(code)) |=> state == status_led_pkg::ST_GAP)
		else $error("flash group did not end at its code count");

	AST_GAP_DARK: assert property ( // [RQ8]
		state == status_led_pkg::ST_GAP |=> !o_led_red && !o_led_green)
		else $error("LED lit during inter-group gap");

	AST_BUS_STEADY: assert property ( // [RQ2]
		(state == status_led_pkg::ST_NORMAL && !i_dmx_mode && act_cnt == '0)
		|=> o_led_green)
		else $error("green not steady in idle panel-bus mode");

	AST_BUS_BLANK: assert property ( // [RQ3]
		(state == status_led_pkg::ST_NORMAL && !i_dmx_mode && act_cnt == '0
			&& i_bus_data_valid) |=> ##1 !o_led_green)
		else $error("data strobe did not blank green");

	AST_SUPPLY_OFF: assert property ( // [RQ12]
		i_bus_supply_oc |=> !o_bus_supply_en ##1 !o_bus_supply_en)
		else $error("bus supply not switched off after over-current");

	AST_HEATER_LATCH: assert property ( // [RQ13]
		heater_trip |=> heater_trip && !o_heater_en)
		else $error("heater output restored without power cycle");

	AST_PAN_OC: assert property ( // [RQ10]
		i_motor_oc[0] |=> !o_motor_en[0] && oc_flag[0]
			##1 fault_q[status_led_pkg::CODE_PAN_OC-1])
		else $error("pan drive not disabled on over-current");

endmodule // status_led_fault_indicator

// file: rtl/status_led_pkg.sv
// Constants, register map and state type for the status LED fault indicator.
// Assumes a single 20 MHz system clock; all times are turned into cycle counts here.
package status_led_pkg;

	// Clock and derived cycle counts
	localparam int CLOCK_HZ     = 20_000_000;
	localparam int CYC_PER_MS   = CLOCK_HZ / 1000;
	localparam int FLASH_ON_MS  = 250;
	localparam int FLASH_OFF_MS = 250;
	localparam int GAP_MS       = 1500;
	localparam int SLOW_HALF_MS = 500;
	localparam int DMX_LOSS_MS  = 1000;
	localparam int OC_HOLD_MS   = 2000;
	localparam int FLASH_ON_CYC  = FLASH_ON_MS * CYC_PER_MS;
	localparam int FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
	localparam int GAP_CYC       = GAP_MS * CYC_PER_MS;
	localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
	localparam int DMX_LOSS_CYC  = DMX_LOSS_MS * CYC_PER_MS;
	localparam int OC_HOLD_CYC   = OC_HOLD_MS * CYC_PER_MS;

	// Widths
	localparam int NUM_CODES = 11;
	localparam int CODE_W    = 4;
	localparam int LIMIT_W   = 4;
	localparam int MOTORS    = 3;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int TIMER_W   = 32;

	// Firmware version shown at power-up as a count of green flashes
	localparam logic [7:0] SW_VERSION = 8'h03;

	// Fault codes, one flash group length each
	localparam logic [CODE_W-1:0] CODE_NONE       = 4'h0;
	localparam logic [CODE_W-1:0] CODE_PAN_LIMIT  = 4'h1;
	localparam logic [CODE_W-1:0] CODE_TILT_LIMIT = 4'h2;
	localparam logic [CODE_W-1:0] CODE_PAN_OC     = 4'h3;
	localparam logic [CODE_W-1:0] CODE_TILT_OC    = 4'h4;
	localparam logic [CODE_W-1:0] CODE_FOCUS_OC   = 4'h5;
	localparam logic [CODE_W-1:0] CODE_BUS_OC     = 4'h6;
	localparam logic [CODE_W-1:0] CODE_HEATER_OC  = 4'h7;
	localparam logic [CODE_W-1:0] CODE_LIMIT_ERR  = 4'h8;
	localparam logic [CODE_W-1:0] CODE_DATUM      = 4'h9;
	localparam logic [CODE_W-1:0] CODE_PRODUCT    = 4'hA;
	localparam logic [CODE_W-1:0] CODE_SUPPLY     = 4'hB;

	// Limit input bit positions
	localparam int LIM_PAN_CW  = 0;
	localparam int LIM_PAN_CCW = 1;
	localparam int LIM_TILT_UP = 2;
	localparam int LIM_TILT_DN = 3;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FAULTS     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LIMIT_USE  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_INFO       = 8'h10;

	// Reset values and info field positions
	localparam logic [LIMIT_W-1:0]   LIMIT_USE_RST = 4'hF;
	localparam logic [NUM_CODES-1:0] IRQ_MASK_RST  = 11'h000;
	localparam int INFO_CODE_LSB = 8;
	localparam int INFO_MODE_BIT = 12;
	localparam int INFO_GRN_BIT  = 13;
	localparam int INFO_RED_BIT  = 14;

	typedef enum {ST_VER_ON, ST_VER_OFF, ST_NORMAL, ST_FAULT_ON, ST_FAULT_OFF, ST_GAP} led_state_t;

endpackage

// file: tb/status_led_field.sv
// Far-side model: fault sensing lines driven from a code request, red flash groups counted.
// Assumes the bench clock and flash timings shorter than DARK_CYC dark cycles.
`timescale 1ns/1ns

module status_led_field #(
	parameter int DARK_CYC = 6
) (
	// Clock, code request and LED
	input  wire logic        i_clock,
	input  wire logic [10:0] i_req,
	input  wire logic        i_led_red,
	// Fault sensing lines
	output logic      [3:0]  o_limit_sw,
	output logic             o_pan_var,
	output logic             o_tilt_var,
	output logic      [2:0]  o_motor_oc,
	output logic             o_bus_oc,
	output logic             o_heater_oc,
	output logic             o_datum,
	output logic             o_product,
	output logic             o_supply,
	// Group report
	output int               o_last_len,
	output int               o_groups
);
	int   flashes;
	int   dark;
	logic red_q;

	// Each requested code raises one sensing line, code 2 two (tilt variable and tilt-up limit); code 8 uses a pan limit the product lacks
	assign o_pan_var   = i_req[0];
	assign o_tilt_var  = i_req[1];
	assign o_limit_sw  = {1'b0, i_req[1], i_req[7], 1'b0};
	assign o_motor_oc  = i_req[4:2];
	assign o_bus_oc    = i_req[5];
	assign o_heater_oc = i_req[6];
	assign o_datum     = i_req[8];
	assign o_product   = i_req[9];
	assign o_supply    = i_req[10];

	// A dark spell longer than a flash gap closes the group
	always @(posedge i_clock) begin
		red_q <= i_led_red;
		if (i_led_red && !red_q)
			flashes <= flashes + 1;
		dark <= i_led_red ? 0 : dark + 1;
		if (!i_led_red && dark == DARK_CYC && flashes > 0) begin
			o_last_len <= flashes;
			o_groups   <= o_groups + 1;
			flashes    <= 0;
		end
	end
endmodule // status_led_field

// file: tb/status_led_fault_indicator_tb_top.sv
// Bench for the status LED indicator: version, green modes, fault codes, registers, trips.
// Assumes short flash timings so every group fits in a few hundred cycles.
`timescale 1ns/1ns

module status_led_fault_indicator_tb_top;
	localparam int SLOW = 8;
	localparam int LOSS = 20;
	localparam int HOLD = 16;
	logic        i_clock = 0, i_rst_n = 0, i_dmx_mode = 0, i_bus_data_valid = 0;
	logic        i_dmx_data_valid = 0, i_wr = 0, i_rd = 0, grn_q = 0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, rd;
	logic [10:0] req = 11'h000;
	logic [3:0]  lim;
	logic [2:0]  moc, men;
	logic        pv, tv, bus_oc, heat_oc, datum, prod, sup, grn, red, bus_en, heat_en, irq;
	int errors = 0, n_checks = 0, seed = 95918, cycles = 0, falls = 0;
	int last_len, groups, g1, g2, n, k;
	int exp_q [$];
	int order [11] = '{1, 2, 3, 4, 5, 8, 9, 10, 11, 6, 7};

	status_led_fault_indicator #(.FLASH_ON_CYC(4), .FLASH_OFF_CYC(4), .GAP_CYC(10),
		.SLOW_HALF_CYC(SLOW), .DMX_LOSS_CYC(LOSS), .OC_HOLD_CYC(HOLD)) uut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_dmx_mode(i_dmx_mode),
		.i_bus_data_valid(i_bus_data_valid), .i_dmx_data_valid(i_dmx_data_valid),
		.i_limit_sw(lim), .i_pan_var_limit(pv), .i_tilt_var_limit(tv), .i_motor_oc(moc),
		.i_bus_supply_oc(bus_oc), .i_heater_oc(heat_oc), .i_datum_fail(datum),
		.i_product_bad(prod), .i_supply_bad(sup), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_led_green(grn), .o_led_red(red),
		.o_motor_en(men), .o_bus_supply_en(bus_en), .o_heater_en(heat_en), .o_irq(irq));

	status_led_field field (.i_clock(i_clock), .i_req(req), .i_led_red(red),
		.o_limit_sw(lim), .o_pan_var(pv), .o_tilt_var(tv), .o_motor_oc(moc),
		.o_bus_oc(bus_oc), .o_heater_oc(heat_oc), .o_datum(datum), .o_product(prod),
		.o_supply(sup), .o_last_len(last_len), .o_groups(groups));

	// Clock
	initial begin
		forever #25 i_clock = ~i_clock;
	end

	// Hang guard, and green falling edges since the last reset
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		grn_q <= grn;
		falls <= !i_rst_n ? 0 : falls + (grn_q && !grn);
		if (cycles == 30000) begin
			errors++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Sampling on the falling edge keeps checks clear of the launching edge
	task automatic cyc(input int c);
		repeat (c) @(negedge i_clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr <= 1; i_addr <= a; i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdr(input logic [7:0] a);
		@(posedge i_clock);
		i_rd <= 1; i_addr <= a;
		@(posedge i_clock);
		i_rd <= 0;
		@(negedge i_clock);
		rd = o_rdata;
	endtask

	// Latched trips only clear through reset, so the last cases reset first
	task automatic do_reset();
		@(posedge i_clock) i_rst_n <= 0;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1;
		wr(8'h0C, 32'hD);
		wr(8'h04, 32'h7FF);
	endtask

	task automatic next_group(output int len);
		int g0;
		g0 = groups;
		k = 0;
		while (groups == g0 && k < 400) begin
			cyc(1);
			k++;
		end
		len = (groups == g0) ? 0 : last_len;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1;
		cyc(40);
		chk("version flashes", status_led_pkg::SW_VERSION, falls);
		chk("steady green", 1, grn);
		rdr(8'h0C); chk("limit use reset", 32'hF, rd);
		rdr(8'h04); chk("mask reset", 32'h0, rd);
		rdr(8'h10); chk("version field", {24'h0, status_led_pkg::SW_VERSION}, rd & 32'hFF);
		rdr(8'h20); chk("unmapped read", 32'h0, rd);
		wr(8'h08, 32'h7FF); rdr(8'h08); chk("read-only faults", 32'h0, rd);
		k = $random(seed);
		wr(8'h04, k); rdr(8'h04); chk("mask readback", k & 32'h7FF, rd);
		$display("registers done");
		@(posedge i_clock) i_bus_data_valid <= 1;
		@(posedge i_clock) i_bus_data_valid <= 0;
		cyc(3); chk("panel blank", 0, grn);
		cyc(2 * SLOW); chk("after blank", 1, grn);
		k = falls;
		@(posedge i_clock) i_bus_data_valid <= 1;
		repeat (48) @(posedge i_clock);
		i_bus_data_valid <= 0;
		cyc(1); chk("slow panel flash", 1, falls - k >= 2);
		$display("panel mode done");
		@(posedge i_clock) i_dmx_mode <= 1;
		k = falls;
		repeat (12) begin
			@(posedge i_clock) i_dmx_data_valid <= 1;
			@(posedge i_clock) i_dmx_data_valid <= 0;
			cyc(2);
		end
		chk("dmx slow flash", 1, falls - k >= 2);
		cyc(LOSS + 2 * SLOW + 4);
		k = falls;
		cyc(30); chk("dmx idle steady", 1, falls == k && grn === 1'b1);
		@(posedge i_clock) i_dmx_mode <= 0;
		$display("dmx mode done");
		do_reset();
		for (int i = 0; i < 11; i++) begin
			n = order[i];
			if (n == 6 || n == 7)
				do_reset();
			@(posedge i_clock) req <= 11'h1 << (n - 1);
			// Groups go in ascending code order, so code 8 shows its pan limit first
			exp_q.push_back(n == 8 ? 1 : n);
			exp_q.push_back(n);
			next_group(g1);
			next_group(g2);
			if (n == 8) begin
				chk("pair first", exp_q.pop_front(), g1);
				chk("pair second", exp_q.pop_front(), g2);
			end else begin
				chk("group length", exp_q.pop_front(), g1);
				chk("group repeat", exp_q.pop_front(), g2);
			end
			rdr(8'h08); chk("fault vector", n == 8 ? 32'h81 : 32'h1 << (n - 1), rd);
			chk("irq raised", 1, irq);
			if (n == 11) begin
				wr(8'h04, 32'h0); cyc(2); chk("irq masked", 0, irq);
				wr(8'h04, 32'h7FF);
			end
			wr(8'h00, 32'h7FF); cyc(3); chk("irq cleared", 0, irq);
			@(posedge i_clock) req <= 11'h000;
			cyc(2);
			if (n >= 3 && n <= 5) chk("motor off", 0, men[n - 3]);
			if (n == 6) chk("bus supply off", 0, bus_en);
			if (n == 7) chk("heater off", 0, heat_en);
			cyc(HOLD + 120);
			if (n == 6 || n == 7) begin
				rdr(8'h08); chk("trip latched", 32'h1 << (n - 1), rd);
				chk("trip held off", 0, n == 6 ? bus_en : heat_en);
			end else begin
				chk("green back", 2'b10, {grn, red});
				chk("motors back", 3'b111, men);
				rdr(8'h08); chk("faults gone", 0, rd);
			end
			$display("fault code %0d done", n);
		end
		finish_test();
	end
endmodule // status_led_fault_indicator_tb_top
